//--- hdl/slm_pkg.sv
/*
  Shared constants and types of the serial link mode datapath: register map,
  control field positions, character lengths, line code tables and mode codes.
  Assumes a 32-bit APB master and a single 125 MHz system clock.
*/
package slm_pkg;

  // ==========================================================================
  // Clock and buffer sizing
  localparam int unsigned CLK_SYS_HZ        = 125_000_000;
  localparam int unsigned TX_FIFO_DEPTH_DEF = 256;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_VIOL_CNT = 12'h008;

  // Control fields
  localparam int CTRL_FIFO_BYPASS  = 0;
  localparam int CTRL_CODEC_BYPASS = 1;
  localparam int CTRL_CHAR_WIDTH   = 2;
  localparam int CTRL_SPEED_BAND   = 3;
  localparam int CTRL_MULT_RANGE   = 4;
  localparam int CTRL_FRAMER_ALLOW = 5;
  localparam int CTRL_DISCARD_LO   = 6;
  localparam int CTRL_WIDTH        = 8;
  localparam logic [7:0] CTRL_RESET = 8'h24;

  // Status fields
  localparam int STAT_OFFSET_LO = 0;
  localparam int STAT_MULT_LO   = 4;
  localparam int STAT_TXMODE_LO = 6;
  localparam int STAT_RXMODE_LO = 10;
  localparam int STAT_FIFO_EMPTY = 14;
  localparam int STAT_LEVEL_LO  = 16;
  localparam int STAT_LEVEL_W   = 9;

  // ==========================================================================
  // Character lengths on the line
  localparam logic [3:0] BYTE_CHAR_BITS = 4'ha;
  localparam logic [3:0] WIDE_CHAR_BITS = 4'hc;

  // Line symbols, written first-sent bit on the left
  localparam logic [9:0]  BYTE_SYNC_SYM = 10'h311;
  localparam logic [11:0] WIDE_SYNC_SYM = 12'h623;
  localparam logic [9:0]  BYTE_VIOL_SYM = 10'h021;
  localparam logic [11:0] WIDE_VIOL_SYM = 12'h041;

  localparam logic [4:0] NIBBLE_CODE [0:15] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  localparam logic [9:0] BYTE_CMD_SYM [0:15] = '{
    10'h311, 10'h3ff, 10'h1ad, 10'h1b9, 10'h3e4, 10'h1a7, 10'h327, 10'h339,
    10'h084, 10'h09f, 10'h080, 10'h0e7, 10'h0f9, 10'h004, 10'h01f, 10'h000};

  localparam logic [11:0] WIDE_CMD_SYM [0:3] = '{
    12'h623, 12'hfff, 12'h75d, 12'h779};

  // ==========================================================================
  // Modes and carriers
  typedef enum logic [1:0] {
    MULT_X2P5 = 2'h0,
    MULT_X5   = 2'h1,
    MULT_X10  = 2'h2
  } slm_mult_type;

  typedef enum logic [3:0] {
    TX_SYNC_ENC  = 4'h1,
    TX_SYNC_PRE  = 4'h2,
    TX_ASYNC_ENC = 4'h4,
    TX_ASYNC_PRE = 4'h8
  } slm_tx_mode_type;

  typedef enum logic [3:0] {
    RX_SYNC_DEC    = 4'h1,
    RX_SYNC_RAW    = 4'h2,
    RX_ASYNC_DEC   = 4'h4,
    RX_ASYNC_RAW   = 4'h8
  } slm_rx_mode_type;

  typedef struct packed {
    logic       viol;
    logic       special;
    logic [3:0] cmd;
    logic [9:0] data;
  } slm_tx_char_type;

endpackage

//--- hdl/slm_mode_datapath.sv
/*
  Mode control and parallel datapath of a serial transceiver: optional
  256-character transmit FIFO, line encoder, serializer,
  deserializer with framer, decoder and receive output register, and an APB
  register file for the mode selects.
  Assumes one bit per CLK_SYS on transmit, a recovered bit stream that arrives
  as RX_SERIAL_BIT qualified by RX_BIT_VALID, and all inputs synchronous.
*/
`timescale 1ns/100ps
module slm_mode_datapath
  import slm_pkg::*;
#(
  parameter int TX_FIFO_DEPTH = TX_FIFO_DEPTH_DEF
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [9:0]  TX_PARALLEL_BUS,
  input  wire logic [3:0]  TX_COMMAND_FIELD,
  input  wire logic        TX_SPECIAL_SELECT,
  input  wire logic        TX_SEND_VIOLATION,
  input  wire logic        TX_CHAR_VALID,
  input  wire logic        TX_FIFO_WRITE,
  input  wire logic        TX_FIFO_RESET_IN,
  input  wire logic        TX_PAUSE_IN,
  output logic             TX_FIFO_READY,
  output logic             REF_CHAR_TICK,
  output logic             TX_SERIAL_BIT,
  output logic      [1:0]  SERIAL_MULT_CODE,
  input  wire logic        RX_SERIAL_BIT,
  input  wire logic        RX_BIT_VALID,
  output logic      [11:0] RX_PARALLEL_BUS,
  output logic             RX_SPECIAL_FLAG,
  output logic             RX_NODATA_FLAG_N,
  output logic             CODE_VIOLATION_FLAG,
  output logic             RX_CHAR_STROBE
);

  localparam int AW = $clog2(TX_FIFO_DEPTH);

  if (TX_FIFO_DEPTH < 4 || TX_FIFO_DEPTH > 256 || (1 << AW) != TX_FIFO_DEPTH) begin : g_chk
    $error("TX_FIFO_DEPTH must be a power of two from 4 to 256");
  end

  // ==========================================================================
  // Helpers
  function automatic logic [11:0] slm_rev(input logic [11:0] v, input logic wide);
    logic [11:0] r;
    r = '0;
    for (int i = 0; i < 12; i++) begin
      if (wide) begin
        r[i] = v[11-i];
      end else if (i < 10) begin
        r[i] = v[9-i];
      end
    end
    return r;
  endfunction

  // Returns {code valid, nibble}
  function automatic logic [4:0] slm_dec5(input logic [4:0] s);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (NIBBLE_CODE[i] == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // APB register file
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [15:0]           viol_cnt;
  logic [3:0]            frame_offset;
  logic [31:0]           status_word;
  logic [31:0]           rd_mux;
  logic                  sel_ctrl;
  logic                  sel_status;
  logic                  sel_viol;
  logic                  mapped;
  logic                  wr_access;
  logic                  rx_viol_event;

  assign sel_ctrl   = PADDR == ADDR_CTRL;
  assign sel_status = PADDR == ADDR_STATUS;
  assign sel_viol   = PADDR == ADDR_VIOL_CNT;
  assign mapped     = sel_ctrl | sel_status | sel_viol;
  assign wr_access  = PSEL & PENABLE & PWRITE & mapped;
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL & PENABLE & ~mapped;
  assign rd_mux     = sel_ctrl   ? {24'h000000, ctrl} :
                      sel_status ? status_word :
                      sel_viol   ? {16'h0000, viol_cnt} : 32'h00000000;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl   <= CTRL_RESET;
      PRDATA <= 32'h00000000;
    end else begin
      if (PSEL & ~PENABLE) begin
        PRDATA <= rd_mux;
      end
      if (wr_access & sel_ctrl) begin
        ctrl <= PWDATA[CTRL_WIDTH-1:0];
      end
    end
  end

  // A violation in the clearing cycle still counts as one
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      viol_cnt <= 16'h0000;
    end else if (wr_access & sel_viol) begin
      viol_cnt <= {15'h0000, rx_viol_event};
    end else if (rx_viol_event && viol_cnt != 16'hffff) begin
      viol_cnt <= viol_cnt + 16'h0001;
    end
  end

  // ==========================================================================
  // Mode decode
  logic            fifo_bypass_select;
  logic            codec_bypass_select;
  logic            char_width_select;
  logic            framer_allow;
  logic [1:0]      discard_policy;
  logic            wide;
  logic            tx_sync;
  logic [3:0]      char_len;
  slm_tx_mode_type tx_mode;
  slm_rx_mode_type rx_mode;
  slm_mult_type    next_mult;

  assign fifo_bypass_select  = ctrl[CTRL_FIFO_BYPASS];
  assign codec_bypass_select = ctrl[CTRL_CODEC_BYPASS];
  assign char_width_select   = ctrl[CTRL_CHAR_WIDTH];
  assign framer_allow        = ctrl[CTRL_FRAMER_ALLOW];
  assign discard_policy      = ctrl[CTRL_DISCARD_LO +: 2];
  // Width select high means byte characters with 4-bit commands
  assign wide     = ~char_width_select;
  assign char_len = wide ? WIDE_CHAR_BITS : BYTE_CHAR_BITS;
  // FIFO bypass low selects the synchronous transmit modes
  assign tx_sync  = ~fifo_bypass_select;
  assign tx_mode  = tx_sync ? (codec_bypass_select ? TX_SYNC_PRE : TX_SYNC_ENC)
                            : (codec_bypass_select ? TX_ASYNC_PRE : TX_ASYNC_ENC);
  assign rx_mode  = tx_sync ? (codec_bypass_select ? RX_SYNC_RAW : RX_SYNC_DEC)
                            : (codec_bypass_select ? RX_ASYNC_RAW : RX_ASYNC_DEC);
  // Synchronous modes never run at 2.5x
  assign next_mult = tx_sync ? (ctrl[CTRL_MULT_RANGE] ? MULT_X10 : MULT_X5) :
                     (!ctrl[CTRL_SPEED_BAND]) ? MULT_X2P5 :
                     (ctrl[CTRL_MULT_RANGE] ? MULT_X10 : MULT_X5);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      SERIAL_MULT_CODE <= MULT_X10;
    end else begin
      SERIAL_MULT_CODE <= next_mult;
    end
  end

  // ==========================================================================
  // Transmit FIFO, used only in the asynchronous modes
  slm_tx_char_type port_char;
  slm_tx_char_type fifo_head;
  slm_tx_char_type fifo_mem [TX_FIFO_DEPTH];
  logic [AW-1:0]   wr_ptr;
  logic [AW-1:0]   rd_ptr;
  logic [AW:0]     fifo_level;
  logic            fifo_empty;
  logic            fifo_full;
  logic            fifo_push;
  logic            fifo_pop;
  logic            fifo_clear;
  logic            tx_tick;

  assign port_char  = '{viol: TX_SEND_VIOLATION, special: TX_SPECIAL_SELECT,
                        cmd: TX_COMMAND_FIELD, data: TX_PARALLEL_BUS};
  assign fifo_head  = fifo_mem[rd_ptr];
  assign fifo_empty = fifo_level == '0;
  assign fifo_full  = fifo_level == (AW+1)'(TX_FIFO_DEPTH);
  assign fifo_clear = ~tx_sync & TX_FIFO_RESET_IN;
  assign fifo_push  = ~tx_sync & TX_FIFO_WRITE & ~fifo_full & ~TX_FIFO_RESET_IN;
  assign fifo_pop   = ~tx_sync & tx_tick & ~fifo_empty & ~TX_PAUSE_IN;
  assign TX_FIFO_READY = ~tx_sync & ~fifo_full & ~TX_FIFO_RESET_IN;

  always_ff @(posedge CLK_SYS) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr] <= port_char;
    end
  end

  // Accepts one write per clock, which covers any writer up to 125 MHz
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      fifo_level <= '0;
    end else if (fifo_clear) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      fifo_level <= '0;
    end else begin
      wr_ptr     <= wr_ptr + AW'(fifo_push);
      rd_ptr     <= rd_ptr + AW'(fifo_pop);
      fifo_level <= fifo_level + (AW+1)'(fifo_push) - (AW+1)'(fifo_pop);
    end
  end

  // ==========================================================================
  // Encoder and serializer
  slm_tx_char_type src_char;
  logic            src_valid;
  logic [11:0]     data_sym;
  logic [11:0]     cmd_sym;
  logic [11:0]     sync_sym;
  logic [11:0]     enc_sym;
  logic [11:0]     next_word;
  logic [11:0]     tx_shift;
  logic [3:0]      tx_cnt;

  assign tx_tick       = tx_cnt >= char_len - 4'h1;
  assign REF_CHAR_TICK = tx_tick;
  assign src_char  = tx_sync ? port_char : fifo_head;
  // Pause and FIFO reset play no part while synchronous
  assign src_valid = tx_sync ? TX_CHAR_VALID : (~fifo_empty & ~TX_PAUSE_IN);
  assign sync_sym  = wide ? WIDE_SYNC_SYM : {2'b00, BYTE_SYNC_SYM};
  // Wide data halves are a nibble code plus the fifth bit
  assign data_sym  = wide ?
    {NIBBLE_CODE[src_char.data[8:5]], src_char.data[9],
     NIBBLE_CODE[src_char.data[3:0]], src_char.data[4]} :
    {2'b00, NIBBLE_CODE[src_char.data[7:4]], NIBBLE_CODE[src_char.data[3:0]]};
  assign cmd_sym   = wide ? WIDE_CMD_SYM[src_char.cmd[1:0]]
                          : {2'b00, BYTE_CMD_SYM[src_char.cmd]};
  assign enc_sym   = src_char.viol    ? (wide ? WIDE_VIOL_SYM : {2'b00, BYTE_VIOL_SYM}) :
                     src_char.special ? cmd_sym : data_sym;

  always_comb begin
    next_word = slm_rev(sync_sym, wide);
    unique case (tx_mode)
      TX_SYNC_ENC, TX_ASYNC_ENC: begin
        if (src_valid) begin
          next_word = slm_rev(enc_sym, wide);
        end
      end
      TX_SYNC_PRE, TX_ASYNC_PRE: begin
        // Low command bits extend the raw word, sent bit 0 first
        if (src_valid) begin
          next_word = {src_char.cmd[1:0], src_char.data};
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_cnt   <= 4'h0;
      tx_shift <= 12'h000;
    end else if (tx_tick) begin
      tx_cnt   <= 4'h0;
      tx_shift <= next_word;
    end else begin
      tx_cnt   <= tx_cnt + 4'h1;
      tx_shift <= {1'b0, tx_shift[11:1]};
    end
  end

  assign TX_SERIAL_BIT = tx_shift[0];

  // ==========================================================================
  // Deserializer, framer and decoder
  logic [11:0] rx_win;
  logic [11:0] next_win;
  logic [11:0] rx_sym;
  logic [3:0]  rx_cnt;
  logic        sync_hit;
  logic        rx_done;
  logic        decoded;
  logic [4:0]  d_hi;
  logic [4:0]  d_lo;
  logic        data_ok;
  logic        cmd_hit;
  logic [3:0]  cmd_idx;
  logic [9:0]  rx_data;
  logic        rx_bad;
  logic        rx_is_sync;

  assign next_win = {rx_win[10:0], RX_SERIAL_BIT};
  assign rx_sym   = wide ? next_win : {2'b00, next_win[9:0]};
  assign sync_hit = framer_allow & RX_BIT_VALID &
                    (rx_sym == sync_sym);
  assign rx_done  = RX_BIT_VALID & ((rx_cnt >= char_len - 4'h1) | sync_hit);
  assign decoded  = ~codec_bypass_select;
  assign d_hi     = wide ? slm_dec5(rx_sym[11:7]) : slm_dec5(rx_sym[9:5]);
  assign d_lo     = wide ? slm_dec5(rx_sym[5:1])  : slm_dec5(rx_sym[4:0]);
  assign data_ok  = d_hi[4] & d_lo[4];
  assign rx_data  = wide ? {rx_sym[6], d_hi[3:0], rx_sym[0], d_lo[3:0]}
                         : {2'b00, d_hi[3:0], d_lo[3:0]};

  always_comb begin
    cmd_hit = 1'b0;
    cmd_idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (!cmd_hit && (wide ? (i < 4 && rx_sym == WIDE_CMD_SYM[i & 3])
                            : rx_sym[9:0] == BYTE_CMD_SYM[i])) begin
        cmd_hit = 1'b1;
        cmd_idx = 4'(i);
      end
    end
  end

  assign rx_is_sync    = cmd_hit & (cmd_idx == 4'h0);
  assign rx_bad        = decoded & ~cmd_hit & ~data_ok;
  assign rx_viol_event = rx_done & rx_bad;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_win       <= 12'h000;
      rx_cnt       <= 4'h0;
      frame_offset <= 4'h0;
    end else if (RX_BIT_VALID) begin
      rx_win <= next_win;
      rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'h1;
      if (sync_hit) begin
        frame_offset <= rx_cnt;
      end
    end
  end

  // Output register: the receive FIFO is not built, so all receive classes
  // present characters here as they complete
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      RX_PARALLEL_BUS     <= 12'h000;
      RX_SPECIAL_FLAG     <= 1'b0;
      RX_NODATA_FLAG_N    <= 1'b1;
      CODE_VIOLATION_FLAG <= 1'b0;
      RX_CHAR_STROBE      <= 1'b0;
    end else begin
      RX_CHAR_STROBE <= rx_done;
      if (rx_done) begin
        if (decoded) begin
          RX_PARALLEL_BUS <= !cmd_hit ? {2'b00, rx_data} :
                             wide ? {cmd_idx[1:0], 10'h000} : {cmd_idx, 8'h00};
          RX_SPECIAL_FLAG <= cmd_hit;
        end else begin
          RX_PARALLEL_BUS <= slm_rev(rx_sym, wide);
          RX_SPECIAL_FLAG <= 1'b0;
        end
        RX_NODATA_FLAG_N    <= ~(decoded & rx_is_sync & (discard_policy != 2'b00));
        CODE_VIOLATION_FLAG <= rx_bad;
      end
    end
  end

  assign status_word = {7'h00, STAT_LEVEL_W'(fifo_level), 1'b0, fifo_empty,
                        rx_mode, tx_mode, SERIAL_MULT_CODE, frame_offset};

  // ==========================================================================
  // Assertions
  sequence s_byte_period;
    (tx_tick && !wide) ##1 (!wide && !tx_tick) [*8] ##1 !wide;
  endsequence

  a_sync_fill_load: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (tx_tick && tx_mode == TX_SYNC_ENC && !TX_CHAR_VALID && !(wr_access && sel_ctrl))
      |=> tx_shift == slm_rev(sync_sym, wide))
    else $error("sync fill not loaded");

  a_pre_bit_order: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (tx_tick && tx_mode == TX_SYNC_PRE && TX_CHAR_VALID && !wide)
      |=> TX_SERIAL_BIT == $past(TX_PARALLEL_BUS[0]) ##1
          TX_SERIAL_BIT == $past(TX_PARALLEL_BUS[1], 2))
    else $error("pre-encoded bit order wrong");

  a_sync_pause_ign: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (tx_tick && tx_mode == TX_SYNC_PRE && TX_CHAR_VALID && TX_PAUSE_IN)
      |=> tx_shift[9:0] == $past(TX_PARALLEL_BUS))
    else $error("pause acted in synchronous mode");

  a_fifo_pause_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (!tx_sync && TX_PAUSE_IN && !TX_FIFO_RESET_IN && !TX_FIFO_WRITE)
      |=> fifo_level == $past(fifo_level))
    else $error("FIFO drained while paused");

  a_byte_char_period: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    s_byte_period |=> tx_tick)
    else $error("byte character period not ten cycles");

  // Framer off: the boundary counter only advances, never jumps to a sync
  a_framer_gate: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (!framer_allow && RX_BIT_VALID && rx_cnt < char_len - 4'h1)
      |=> rx_cnt == $past(rx_cnt) + 4'h1)
    else $error("framer active while disallowed");

  a_frame_realign: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    sync_hit |=> RX_CHAR_STROBE && rx_cnt == 4'h0 && frame_offset == $past(rx_cnt))
    else $error("boundary not moved to sync");

  a_nodata_on_sync: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (rx_done && decoded && rx_is_sync && discard_policy != 2'b00)
      |=> !RX_NODATA_FLAG_N && RX_SPECIAL_FLAG)
    else $error("no-data flag not low on sync");

  a_viol_flag_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (rx_done && rx_bad) |=> CODE_VIOLATION_FLAG ##1
      (CODE_VIOLATION_FLAG || RX_CHAR_STROBE))
    else $error("violation flag not held for the character");

  a_raw_no_viol: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (rx_done && !decoded) |=> !CODE_VIOLATION_FLAG && !RX_SPECIAL_FLAG)
    else $error("violation reported without decoder");

endmodule

//--- dv/slm_line_partner.sv
/*
  Far end of the serial line: a remote transceiver reduced to a loopback
  that hands every sent bit back as one recovered bit.
  Assumes one line bit per clock on the transmit side.
*/
`timescale 1ns/100ps
module slm_line_partner (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tx_bit,
  output logic      rx_bit,
  output logic      rx_valid
);
  // ==================
  // Loopback
  // One stage of delay so the far end never answers within the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_bit   <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_bit   <= tx_bit;
      rx_valid <= 1'b1;
    end
  end
endmodule

//--- dv/testbench.sv
/*
  Self-checking bench: APB mode set-up, transmit modes, receive via loopback
  and the transmit FIFO. Assumes the line partner closes the serial loop.
*/
`timescale 1ns/100ps
module testbench
  import slm_pkg::*;
;
  // ==================
  // Signals
  logic        clk, rst_n, psel, pen, pwr, pready, pslverr, er;
  logic [11:0] paddr, rxd, sym, ex;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  txd;
  logic [3:0]  txc;
  logic        tx_sp, tx_sv, tx_en, tx_fw, tx_fr, tx_pa, tx_rdy, tick, tx_bit;
  logic [1:0]  mult;
  logic        rx_bit, rx_vld, rx_sp, rx_nd_n, viol, rx_stb;
  int          fails, cmp_count, gap;

  slm_mode_datapath slm_mode_datapath_i (
    .CLK_SYS(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TX_PARALLEL_BUS(txd), .TX_COMMAND_FIELD(txc),
    .TX_SPECIAL_SELECT(tx_sp), .TX_SEND_VIOLATION(tx_sv), .TX_CHAR_VALID(tx_en),
    .TX_FIFO_WRITE(tx_fw), .TX_FIFO_RESET_IN(tx_fr), .TX_PAUSE_IN(tx_pa),
    .TX_FIFO_READY(tx_rdy), .REF_CHAR_TICK(tick), .TX_SERIAL_BIT(tx_bit),
    .SERIAL_MULT_CODE(mult), .RX_SERIAL_BIT(rx_bit), .RX_BIT_VALID(rx_vld),
    .RX_PARALLEL_BUS(rxd), .RX_SPECIAL_FLAG(rx_sp), .RX_NODATA_FLAG_N(rx_nd_n),
    .CODE_VIOLATION_FLAG(viol), .RX_CHAR_STROBE(rx_stb));

  slm_line_partner slm_line_partner_i (
    .clk(clk), .rst_n(rst_n), .tx_bit(tx_bit), .rx_bit(rx_bit), .rx_valid(rx_vld));

  // ==================
  // Shared tasks
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // Line order: first bit sent ends up leftmost in sym
  task automatic tx_cap(input int n);
    sym = '0;
    gap = 0;
    @(negedge clk);
    while (tick !== 1'b1) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      sym = {sym[10:0], tx_bit};
      if (tick === 1'b1 && gap == 0) gap = i + 1;
    end
  endtask

  task automatic rx_next();
    @(negedge clk);
    while (rx_stb !== 1'b1) @(negedge clk);
  endtask

  // ==================
  // Scenarios
  task automatic t_reset();
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd === 32'h24 && er === 1'b0, "ctrl reset");
    apb(1'b0, 12'h00c, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
  endtask

  // FIFO reset and pause held high: synchronous modes must not care
  task automatic t_sync_fill();
    int n;
    tx_fr <= 1'b1;
    tx_pa <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      n = w ? 12 : 10;
      apb(1'b1, ADDR_CTRL, w ? 32'h20 : 32'h24);
      tx_cap(n);
      tx_cap(n);
      chk(sym === (w ? WIDE_SYNC_SYM : {2'h0, BYTE_SYNC_SYM}), "sync fill");
      chk(gap == n && tx_rdy === 1'b0, "char period");
      repeat (4) rx_next();
      chk(rxd === 12'h000 && rx_sp === 1'b1, "sync rx");
    end
    chk(mult === 2'h1 && rx_nd_n === 1'b1, "sync mult");
  endtask

  task automatic t_data();
    apb(1'b1, ADDR_CTRL, 32'h64);
    repeat (3) rx_next();
    chk(rx_nd_n === 1'b0, "discard sync");
    @(posedge clk);
    txd   <= 10'h05a;
    tx_en <= 1'b1;
    tx_cap(10);
    tx_cap(10);
    chk(sym[9:0] === {NIBBLE_CODE[5], NIBBLE_CODE[10]}, "data code");
    repeat (3) rx_next();
    chk(rxd[7:0] === 8'h5a && rx_sp === 1'b0 && viol === 1'b0 && rx_nd_n === 1'b1,
        "data rx");
    @(posedge clk);
    tx_sp <= 1'b1;
    txc   <= 4'h3;
    tx_cap(10);
    tx_cap(10);
    chk(sym[9:0] === BYTE_CMD_SYM[3], "cmd code");
    repeat (3) rx_next();
    chk(rxd[11:8] === 4'h3 && rx_sp === 1'b1, "cmd rx");
    @(posedge clk);
    tx_sv <= 1'b1;
    repeat (3) rx_next();
    chk(viol === 1'b1, "violation rx");
    apb(1'b0, ADDR_VIOL_CNT, 32'h0);
    chk(rd[31:16] === 16'h0000 && rd[15:0] > 16'h0000, "violation count");
    tx_sv <= 1'b0;
    tx_sp <= 1'b0;
  endtask

  task automatic t_pre();
    // Framer off here; the raw pattern holds no sync, so alignment must stay
    apb(1'b1, ADDR_CTRL, 32'h06);
    txd <= 10'h2b5;
    txc <= 4'h2;
    tx_cap(10);
    tx_cap(10);
    ex = {<<{txd}};
    chk({sym[9:0], 2'h0} === ex, "pre byte");
    repeat (3) rx_next();
    chk(rxd === {2'h0, txd} && rx_sp === 1'b0 && viol === 1'b0, "raw rx");
    apb(1'b1, ADDR_CTRL, 32'h22);
    tx_cap(12);
    tx_cap(12);
    ex = {<<{txc[1:0], txd}};
    chk(sym === ex, "pre wide");
  endtask

  // Fill while paused, then drain; full must refuse at exactly the depth
  task automatic t_async();
    @(posedge clk);
    tx_fr <= 1'b0;
    txd   <= 10'h03c;
    apb(1'b1, ADDR_CTRL, 32'h25);
    // Multiplier code follows the control word one cycle late
    repeat (2) @(negedge clk);
    chk(tx_rdy === 1'b1 && mult === 2'h0, "async ready");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[STAT_TXMODE_LO +: 4] === TX_ASYNC_ENC && rd[STAT_RXMODE_LO +: 4] === RX_ASYNC_DEC &&
        rd[STAT_FIFO_EMPTY] === 1'b1, "status modes");
    @(posedge clk);
    tx_fw <= 1'b1;
    repeat (255) @(posedge clk);
    @(negedge clk);
    chk(tx_rdy === 1'b1, "fifo 255");
    @(posedge clk);
    tx_fw <= 1'b0;
    @(negedge clk);
    chk(tx_rdy === 1'b0, "fifo full");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[STAT_LEVEL_LO +: STAT_LEVEL_W] === STAT_LEVEL_W'(TX_FIFO_DEPTH_DEF) &&
        rd[STAT_FIFO_EMPTY] === 1'b0, "fifo level");
    tx_cap(10);
    chk(sym[9:0] === BYTE_SYNC_SYM, "paused");
    @(posedge clk);
    tx_pa <= 1'b0;
    tx_cap(10);
    tx_cap(10);
    chk(sym[9:0] === {NIBBLE_CODE[3], NIBBLE_CODE[12]}, "fifo data");
    @(posedge clk);
    tx_fr <= 1'b1;
    @(negedge clk);
    chk(tx_rdy === 1'b0, "fifo resetting");
    @(posedge clk);
    tx_fr <= 1'b0;
    tx_cap(10);
    tx_cap(10);
    chk(sym[9:0] === BYTE_SYNC_SYM, "fifo cleared");
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #(20000 * 8);
    fails++;
    end_sim();
  end

  initial begin
    {rst_n, psel, pen, pwr, tx_sp, tx_sv, tx_en, tx_fw, tx_fr, tx_pa} <= '0;
    paddr  <= '0;
    pwdata <= '0;
    txd    <= '0;
    txc    <= '0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk(mult === 2'h2 && rx_nd_n === 1'b1 && tx_bit === 1'b0, "reset outputs");
    @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_sync_fill();
    t_data();
    t_pre();
    t_async();
    end_sim();
  end
endmodule
